// *** legacy_mode_protection_check.sv ***
// Privilege, I/O permission and mode flag checking for the legacy execution mode
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Legacy mode runs at level 3; privileged instructions there or above 0 fault 13
// - Protected-only instructions fault 6 in real or legacy mode
// - In legacy mode int n, sti, cli, push_flags_instr, pop_flags_instr, interrupt_return_instr check I/O level
// - Breakpoint, overflow interrupt and bounds check skip the I/O level check
// - Protected mode port access passes when CURRENT_PRIVILEGE_LEVEL at most I/O level, else bitmap
// - Legacy mode port access always consults the bitmap
// - Bitmap located by a 16-bit base field within the task segment
// - One bitmap bit per byte port address
// - Every spanned bit tested; any one raises general protection fault
// - Ports beyond the end of the bitmap read as ones and trap
// - Legacy mode interrupts vector through the table to a level 0 handler
// - Leaving by interrupt clears the live flag; saved image keeps it set
// - Legacy mode is left only on an interrupt or exception; the code also leaves it on a task switch
// - Entered by 32-bit interrupt_return_instr at level 0 or task switch with flag set
// - Pop flags keeps the mode flag; push flags stores zero there
// - Gate to conforming or nonzero level segment faults with selector error code
// - Task switch out saves flags with the mode bit and segment base values
// - Flags load before segments; segments load as base values when flag set
// - Legacy linear base is segment value shifted left 4 plus offset
// - Legacy addresses above one megabyte fault 13
module legacy_mode_protection_check
   import legacy_prot_pkg::*;
#(
   parameter int unsigned TSS_BYTES = 128
) (
   // Clock and reset
   input  wire logic                            core_clk,
   input  wire logic                            arst_n,
   // Register bus
   input  wire logic [legacy_prot_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]                     reg_wdata,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output logic      [31:0]                     reg_rdata,
   // Check request
   input  wire logic                            req_valid,
   input  wire legacy_prot_pkg::chk_req_s       req,
   // Check answer
   output logic                                 rsp_valid,
   output legacy_prot_pkg::chk_rsp_s            rsp,
   // Live mode state
   output logic                                 legacy_mode_flag,
   output logic      [1:0]                      current_privilege_level
);

   // ==========================================================
   // State
   localparam int unsigned TA_W = $clog2(TSS_BYTES);

   logic [7:0]  tss_mem [TSS_BYTES];
   logic        prot_enable;
   logic [1:0]  io_privilege_level;
   logic [15:0] iomap_base;
   logic [15:0] tss_limit;
   logic [15:0] tss_addr;
   logic        last_fault;
   logic [7:0]  last_vector;

   // ==========================================================
   // Register decode
   wire wr_ctrl  = reg_wr && (reg_addr == OFS_CTRL);
   wire wr_base  = reg_wr && (reg_addr == OFS_IOMAP_BASE);
   wire wr_limit = reg_wr && (reg_addr == OFS_TSS_LIMIT);
   wire wr_taddr = reg_wr && (reg_addr == OFS_TSS_ADDR);
   wire wr_tdata = reg_wr && (reg_addr == OFS_TSS_DATA);

   wire [31:0] ctrl_word = {22'h0, current_privilege_level, 2'h0, io_privilege_level,
                            3'h0, prot_enable};
   wire [31:0] stat_word = {8'h0, last_vector, 2'h0, last_fault, legacy_mode_flag,
                            2'h0, current_privilege_level, 2'h0, io_privilege_level,
                            3'h0, prot_enable};

   function automatic logic [7:0] tss_byte(input logic [16:0] a);
      tss_byte = (a < 17'(TSS_BYTES)) ? tss_mem[a[TA_W-1:0]] : 8'h00;
   endfunction

   // A process, not an assign, so that image writes wake the read path too
   logic [31:0] tss_word;
   always_comb begin
      tss_word = {tss_byte({1'b0, tss_addr} + 17'h3),
                  tss_byte({1'b0, tss_addr} + 17'h2),
                  tss_byte({1'b0, tss_addr} + 17'h1),
                  tss_byte({1'b0, tss_addr})};
   end

   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0;
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_CTRL:       next_rdata = ctrl_word;
            OFS_STATUS:     next_rdata = stat_word;
            OFS_IOMAP_BASE: next_rdata = {16'h0, iomap_base};
            OFS_TSS_LIMIT:  next_rdata = {16'h0, tss_limit};
            OFS_TSS_ADDR:   next_rdata = {16'h0, tss_addr};
            OFS_TSS_DATA:   next_rdata = tss_word;
            default:        next_rdata = 32'h0;
         endcase
      end
   end

   // ==========================================================
   // I/O permission bitmap lookup
   wire [16:0] map_byte0 = {1'b0, iomap_base} +
                           {4'h0, req.io_port[15:PORT_BYTE_SHIFT]};
   wire [16:0] map_byte1 = map_byte0 + 17'h1;

   // Bytes past the segment limit or the held image count as all ones
   function automatic logic [7:0] map_byte(input logic [16:0] a);
      if (a > {1'b0, tss_limit} || a >= 17'(TSS_BYTES))
         map_byte = BYTE_ONES;
      else
         map_byte = tss_mem[a[TA_W-1:0]];
   endfunction

   // A dword at bit 5 or above spills into the next byte, hence two bytes
   logic [15:0] map_pair;
   always_comb begin
      map_pair = {map_byte(map_byte1), map_byte(map_byte0)};
   end
   wire [15:0] map_shift = map_pair >> req.io_port[PORT_BYTE_SHIFT-1:0];
   wire [3:0]  span_mask = (req.io_width == IO_DWORD) ? MASK_DWORD :
                           (req.io_width == IO_WORD)  ? MASK_WORD : MASK_BYTE;
   wire        map_deny  = |(map_shift[3:0] & span_mask);

   // ==========================================================
   // Check decision
   wire in_legacy   = legacy_mode_flag;
   wire in_real     = !prot_enable;
   wire io_privilege_level_short  = current_privilege_level > io_privilege_level;
   wire gate_bad    = req.gate_conforming || (req.gate_dpl != PL_KERNEL);
   wire interrupt_return_instr_enter  = prot_enable && !in_legacy && req.op32 && req.image_vm &&
                      (current_privilege_level == PL_KERNEL);
   wire task_legacy = req.tss32 && req.image_vm;
   wire [20:0] lin_sum = {1'b0, req.selector, 4'h0} + {5'h0, req.offset};

   chk_rsp_s    next_rsp;
   logic        next_vm;
   logic [1:0]  next_cpl;

   always_comb begin
      next_rsp   = '0;
      next_vm    = legacy_mode_flag;
      next_cpl   = current_privilege_level;
      unique case (req.op)
         OP_PRIV: begin
            next_rsp.fault = in_legacy || (current_privilege_level != PL_KERNEL);
         end
         OP_PROT_ONLY: begin
            next_rsp.fault = in_real || in_legacy;
            next_rsp.vector = VEC_UD;
         end
         OP_IO_PRIVILEGE_LEVEL_SENS: begin
            next_rsp.fault = !in_real && io_privilege_level_short;
         end
         OP_FLAGS_SENS: begin
            next_rsp.fault = in_legacy && io_privilege_level_short;
         end
         OP_UNCHECKED: begin
            next_rsp.fault = 1'b0;
         end
         OP_PORT_IO: begin
            if (in_legacy)
               next_rsp.fault = map_deny;
            else if (prot_enable && io_privilege_level_short)
               next_rsp.fault = map_deny;
         end
         OP_INTERRUPT: begin
            next_rsp.image_vm = legacy_mode_flag;
            if (in_legacy && gate_bad) begin
               next_rsp.fault    = 1'b1;
               next_rsp.err_code = req.selector;
            end else if (in_legacy) begin
               next_vm  = 1'b0;
               next_cpl = PL_KERNEL;
            end
         end
         OP_INTERRUPT_RETURN_INSTR: begin
            if (in_legacy)
               next_rsp.fault = io_privilege_level_short;
            else if (interrupt_return_instr_enter) begin
               next_vm  = 1'b1;
               next_cpl = PL_USER;
            end
         end
         OP_TASK_SWITCH: begin
            // Flags image decides first, then segments follow its mode
            next_rsp.image_vm   = legacy_mode_flag;
            next_rsp.seg_legacy = task_legacy;
            if (prot_enable) begin
               next_vm  = task_legacy;
               next_cpl = task_legacy ? PL_USER : req.selector[1:0];
            end
         end
         OP_PUSH_FLAGS: begin
            next_rsp.fault    = in_legacy && io_privilege_level_short;
            next_rsp.image_vm = 1'b0;
         end
         OP_POP_FLAGS: begin
            next_rsp.fault = in_legacy && io_privilege_level_short;
         end
         OP_MEM_REF: begin
            if (in_legacy || in_real) begin
               next_rsp.lin_addr   = lin_sum;
               next_rsp.seg_legacy = 1'b1;
               next_rsp.fault      = lin_sum > LEGACY_ADDR_MAX;
            end
         end
         OP_PLAIN: begin
            next_rsp.fault = 1'b0;
         end
         default: begin
            next_rsp.fault = 1'b0;
         end
      endcase
      if (!next_rsp.fault)
         next_rsp.vector = 8'h00;
      else if (req.op != OP_PROT_ONLY)
         next_rsp.vector = VEC_GP;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prot_enable        <= 1'b0;
         io_privilege_level <= PL_KERNEL;
         iomap_base         <= RST_IOMAP_BASE;
         tss_limit          <= RST_TSS_LIMIT;
         tss_addr           <= 16'h0;
         reg_rdata          <= 32'h0;
      end else begin
         reg_rdata <= next_rdata;
         if (wr_ctrl) begin
            prot_enable        <= reg_wdata[CTRL_PE_BIT];
            io_privilege_level <= reg_wdata[CTRL_IO_PRIVILEGE_LEVEL_LSB +: 2];
         end
         if (wr_base)
            iomap_base <= reg_wdata[15:0];
         if (wr_limit)
            tss_limit <= reg_wdata[15:0];
         if (wr_taddr)
            tss_addr <= reg_wdata[15:0];
         else if (wr_tdata)
            tss_addr <= tss_addr + 16'h4;
      end
   end

   // Image bytes: one lane per byte of the written word
   for (genvar i = 0; i < TSS_BYTES; i++) begin : g_tss
      wire [15:0] lane = 16'(i) - tss_addr;
      always_ff @(posedge core_clk or negedge arst_n) begin
         if (!arst_n)
            tss_mem[i] <= 8'h00;
         else if (wr_tdata && lane < 16'(LANES))
            tss_mem[i] <= reg_wdata[lane[1:0]*8 +: 8];
      end
   end

   // Mode flag and level; software may set the level only outside legacy mode
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         legacy_mode_flag        <= 1'b0;
         current_privilege_level <= PL_KERNEL;
         rsp_valid               <= 1'b0;
         rsp                     <= '0;
         last_fault              <= 1'b0;
         last_vector             <= 8'h0;
      end else begin
         rsp_valid <= req_valid;
         if (req_valid) begin
            rsp                     <= next_rsp;
            legacy_mode_flag        <= next_vm;
            current_privilege_level <= next_cpl;
            last_fault              <= next_rsp.fault;
            last_vector             <= next_rsp.vector;
         end else if (wr_ctrl && !legacy_mode_flag) begin
            current_privilege_level <= reg_wdata[CTRL_CPL_LSB +: 2];
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence seq_legacy_req(instr_class_e c);
      req_valid && legacy_mode_flag && req.op == c;
   endsequence

   sequence seq_good_exit;
      req_valid && legacy_mode_flag && req.op == OP_INTERRUPT && !gate_bad;
   endsequence

   sequence seq_bad_exit;
      req_valid && legacy_mode_flag && req.op == OP_INTERRUPT && gate_bad;
   endsequence

   chk_priv_fault: assert property (
      req_valid && req.op == OP_PRIV && (legacy_mode_flag || current_privilege_level != 2'h0)
      |=> rsp_valid && rsp.fault && rsp.vector == 8'h0d)
      else $error("privileged instruction not faulted");

   chk_prot_only: assert property (
      req_valid && req.op == OP_PROT_ONLY && (!prot_enable || legacy_mode_flag)
      |=> rsp.fault && rsp.vector == 8'h06)
      else $error("protected-only instruction not faulted");

   chk_legacy_level: assert property (
      legacy_mode_flag |-> current_privilege_level == 2'h3)
      else $error("legacy mode not at level 3");

   chk_flags_sens: assert property (
      req_valid && req.op == OP_FLAGS_SENS && !legacy_mode_flag |=> !rsp.fault)
      else $error("flags instruction faulted outside legacy mode");

   chk_unchecked_ok: assert property (
      req_valid && req.op == OP_UNCHECKED |=> rsp_valid && !rsp.fault)
      else $error("unchecked interrupt faulted");

   chk_port_fast: assert property (
      req_valid && req.op == OP_PORT_IO && prot_enable && !legacy_mode_flag &&
      current_privilege_level <= io_privilege_level |=> !rsp.fault)
      else $error("port access blocked despite level");

   chk_port_map: assert property (
      seq_legacy_req(OP_PORT_IO) |=> rsp.fault == $past(map_deny))
      else $error("legacy port access ignored bitmap");

   chk_gate_error: assert property (
      seq_bad_exit
      |=> rsp.fault && rsp.err_code == $past(req.selector) && legacy_mode_flag)
      else $error("bad gate not reported with selector");

   chk_exit_clear: assert property (
      seq_good_exit |=> !legacy_mode_flag && current_privilege_level == 2'h0 &&
      rsp.image_vm ##1 !legacy_mode_flag || rsp_valid)
      else $error("interrupt exit left mode flag wrong");

   chk_stay_legacy: assert property (
      legacy_mode_flag && !(req_valid && (req.op == OP_INTERRUPT ||
      req.op == OP_TASK_SWITCH)) |=> legacy_mode_flag)
      else $error("legacy mode left without interrupt");

   chk_interrupt_return_instr_entry: assert property (
      req_valid && req.op == OP_INTERRUPT_RETURN_INSTR && interrupt_return_instr_enter
      |=> legacy_mode_flag && current_privilege_level == 2'h3)
      else $error("interrupt_return_instr did not enter legacy mode");

   chk_push_image: assert property (
      req_valid && req.op == OP_PUSH_FLAGS |=> !rsp.image_vm)
      else $error("pushed flags image carries mode bit");

   chk_addr_limit: assert property (
      req_valid && req.op == OP_MEM_REF && legacy_mode_flag
      |=> rsp.fault == (rsp.lin_addr > 21'h0fffff))
      else $error("legacy address limit not enforced");

endmodule

`default_nettype wire

// *** legacy_mode_protection_check_tb.sv ***
// Self-checking testbench for the legacy mode protection checker
`timescale 1ns/100ps
`default_nettype none

module legacy_mode_protection_check_tb;
   import legacy_prot_pkg::*;

   // ==========================================================
   // Stimulus and observation
   logic                core_clk  = 1'b0;
   logic                arst_n    = 1'b0;
   logic [ADDR_W-1:0]   reg_addr  = '0;
   logic [31:0]         reg_wdata = '0;
   logic                reg_wr    = 1'b0;
   logic                reg_rd    = 1'b0;
   logic [31:0]         reg_rdata;
   logic                req_valid = 1'b0;
   chk_req_s            req       = '0;
   logic                rsp_valid;
   chk_rsp_s            rsp;
   logic                legacy_mode_flag;
   logic [1:0]          current_privilege_level;
   int                  mismatches = 0;
   int                  checked    = 0;

   always #4 core_clk = ~core_clk;

   legacy_mode_protection_check #(.TSS_BYTES(128)) legacy_mode_protection_check_inst (
      .core_clk                (core_clk),
      .arst_n                  (arst_n),
      .reg_addr                (reg_addr),
      .reg_wdata               (reg_wdata),
      .reg_wr                  (reg_wr),
      .reg_rd                  (reg_rd),
      .reg_rdata               (reg_rdata),
      .req_valid               (req_valid),
      .req                     (req),
      .rsp_valid               (rsp_valid),
      .rsp                     (rsp),
      .legacy_mode_flag        (legacy_mode_flag),
      .current_privilege_level (current_privilege_level)
   );

   // ==========================================================
   // Tasks
   task automatic finish_test();
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // A gap cycle follows each strobe so no strobe is set twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(negedge core_clk);
      cmp(reg_rdata & m, e);
      @(posedge core_clk);
   endtask

   // Flag bits: [0] op32, [1] image mode bit, [2] 32-bit task, [3] conforming, [5:4] gate level
   function automatic chk_req_s mk(instr_class_e op, logic [15:0] s, logic [15:0] p,
                                   io_width_e w, logic [5:0] f);
      chk_req_s q;
      q          = '0;
      q.op       = op;
      q.selector = s;
      q.io_port  = p;
      q.offset   = p;
      q.io_width = w;
      {q.gate_dpl, q.gate_conforming, q.tss32, q.image_vm, q.op32} = f;
      return q;
   endfunction

   // md[3] asks for a mode check: md[2] live flag, md[1:0] live level
   task automatic chk(input chk_req_s q, input logic f, input logic [7:0] v,
                      input logic [3:0] md);
      req       <= q;
      req_valid <= 1'b1;
      @(posedge core_clk);
      req_valid <= 1'b0;
      @(negedge core_clk);
      cmp({30'h0, rsp_valid, rsp.fault}, {30'h0, 1'b1, f});
      cmp({24'h0, rsp.vector}, {24'h0, v});
      if (md[3]) begin
         cmp({29'h0, legacy_mode_flag, current_privilege_level}, {29'h0, md[2:0]});
      end
      @(posedge core_clk);
   endtask

   // ==========================================================
   // Sequence
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      finish_test();
   end

   initial begin
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      rd(OFS_STATUS, 32'hffffffff, 32'h0);
      rd(OFS_IOMAP_BASE, 32'hffff, {16'h0, RST_IOMAP_BASE});
      rd(OFS_TSS_LIMIT, 32'hffff, {16'h0, RST_TSS_LIMIT});
      rd(8'h40, 32'hffffffff, 32'h0);
      // Real mode
      chk(mk(OP_PROT_ONLY, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b1, VEC_UD, 4'h8);
      chk(mk(OP_MEM_REF, 16'h1234, 16'h0010, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'h8);
      cmp({11'h0, rsp.lin_addr}, 32'h12350);
      chk(mk(OP_MEM_REF, 16'hffff, 16'h0010, IO_BYTE, 6'h0), 1'b1, VEC_GP, 4'h8);
      // Task image: bitmap at 0x20, ports 41..44 open, ones byte after the map
      wr(OFS_IOMAP_BASE, 32'h20);
      wr(OFS_TSS_LIMIT, 32'h7f);
      wr(OFS_TSS_ADDR, 32'h20);
      wr(OFS_TSS_DATA, 32'hffffffff);
      wr(OFS_TSS_DATA, 32'hffffe1ff);
      wr(OFS_TSS_DATA, 32'hffffffff);
      wr(OFS_TSS_ADDR, 32'h24);
      rd(OFS_TSS_DATA, 32'hffffffff, 32'hffffe1ff);
      rd(OFS_IOMAP_BASE, 32'hffff, 32'h20);
      // Protected, level 3 above I/O level 0
      wr(OFS_CTRL, 32'h301);
      chk(mk(OP_PRIV, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b1, VEC_GP, 4'hb);
      chk(mk(OP_PROT_ONLY, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'hb);
      chk(mk(OP_PORT_IO, 16'h0, 16'd41, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'hb);
      chk(mk(OP_PORT_IO, 16'h0, 16'd40, IO_BYTE, 6'h0), 1'b1, VEC_GP, 4'hb);
      chk(mk(OP_IO_PRIVILEGE_LEVEL_SENS, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b1, VEC_GP, 4'hb);
      chk(mk(OP_FLAGS_SENS, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'hb);
      chk(mk(OP_INTERRUPT_RETURN_INSTR, 16'h0, 16'h0, IO_BYTE, 6'h01), 1'b0, 8'h0, 4'hb);
      chk(mk(OP_PUSH_FLAGS, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'hb);
      wr(OFS_CTRL, 32'h331);
      chk(mk(OP_PORT_IO, 16'h0, 16'd40, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'hb);
      wr(OFS_CTRL, 32'h031);
      chk(mk(OP_PRIV, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'h8);
      chk(mk(OP_INTERRUPT_RETURN_INSTR, 16'h0, 16'h0, IO_BYTE, 6'h02), 1'b0, 8'h0, 4'h8);
      chk(mk(OP_INTERRUPT_RETURN_INSTR, 16'h0, 16'h0, IO_BYTE, 6'h03), 1'b0, 8'h0, 4'hf);
      rd(OFS_STATUS, 32'h1330, 32'h1330);
      // Current level writes are ignored while the legacy flag is set; I/O level kept at 3
      wr(OFS_CTRL, 32'h031);
      rd(OFS_STATUS, 32'h1330, 32'h1330);
      chk(mk(OP_PORT_IO, 16'h0, 16'd40, IO_BYTE, 6'h0), 1'b1, VEC_GP, 4'hf);
      chk(mk(OP_PORT_IO, 16'h0, 16'd41, IO_DWORD, 6'h0), 1'b0, 8'h0, 4'hf);
      chk(mk(OP_PORT_IO, 16'h0, 16'd42, IO_DWORD, 6'h0), 1'b1, VEC_GP, 4'hf);
      chk(mk(OP_PORT_IO, 16'h0, 16'd43, IO_WORD, 6'h0), 1'b0, 8'h0, 4'hf);
      chk(mk(OP_PORT_IO, 16'h0, 16'h0300, IO_BYTE, 6'h0), 1'b1, VEC_GP, 4'hf);
      chk(mk(OP_PRIV, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b1, VEC_GP, 4'hf);
      chk(mk(OP_PROT_ONLY, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b1, VEC_UD, 4'hf);
      chk(mk(OP_PUSH_FLAGS, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'hf);
      cmp({31'h0, rsp.image_vm}, 32'h0);
      chk(mk(OP_POP_FLAGS, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'hf);
      chk(mk(OP_PLAIN, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'hf);
      chk(mk(OP_MEM_REF, 16'h1234, 16'h0010, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'hf);
      cmp({11'h0, rsp.lin_addr}, 32'h12350);
      chk(mk(OP_MEM_REF, 16'hffff, 16'h0020, IO_BYTE, 6'h0), 1'b1, VEC_GP, 4'hf);
      chk(mk(OP_INTERRUPT, 16'h0018, 16'h0, IO_BYTE, 6'h10), 1'b1, VEC_GP, 4'hf);
      cmp({16'h0, rsp.err_code}, 32'h0018);
      chk(mk(OP_INTERRUPT, 16'h0020, 16'h0, IO_BYTE, 6'h08), 1'b1, VEC_GP, 4'hf);
      cmp({16'h0, rsp.err_code}, 32'h0020);
      chk(mk(OP_INTERRUPT, 16'h0008, 16'h0, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'h8);
      cmp({31'h0, rsp.image_vm}, 32'h1);
      // Entry by task switch, then I/O level 0 checks inside the mode
      wr(OFS_CTRL, 32'h001);
      chk(mk(OP_TASK_SWITCH, 16'h000b, 16'h0, IO_BYTE, 6'h02), 1'b0, 8'h0, 4'hb);
      cmp({31'h0, rsp.seg_legacy}, 32'h0);
      chk(mk(OP_TASK_SWITCH, 16'h000b, 16'h0, IO_BYTE, 6'h06), 1'b0, 8'h0, 4'hf);
      cmp({31'h0, rsp.seg_legacy}, 32'h1);
      chk(mk(OP_IO_PRIVILEGE_LEVEL_SENS, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b1, VEC_GP, 4'hf);
      chk(mk(OP_FLAGS_SENS, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b1, VEC_GP, 4'hf);
      chk(mk(OP_INTERRUPT_RETURN_INSTR, 16'h0, 16'h0, IO_BYTE, 6'h03), 1'b1, VEC_GP, 4'hf);
      chk(mk(OP_UNCHECKED, 16'h0, 16'h0, IO_BYTE, 6'h0), 1'b0, 8'h0, 4'hf);
      chk(mk(OP_TASK_SWITCH, 16'h0008, 16'h0, IO_BYTE, 6'h04), 1'b0, 8'h0, 4'h8);
      cmp({31'h0, rsp.image_vm}, 32'h1);
      finish_test();
   end

endmodule

`default_nettype wire

// *** legacy_prot_pkg.sv ***
// Shared types and constants for the legacy mode protection checker
package legacy_prot_pkg;

   // ==========================================================
   // Register bus
   localparam int unsigned ADDR_W          = 8;
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_STATUS      = 8'h04;
   localparam logic [7:0]  OFS_IOMAP_BASE  = 8'h08;
   localparam logic [7:0]  OFS_TSS_LIMIT   = 8'h0c;
   localparam logic [7:0]  OFS_TSS_ADDR    = 8'h10;
   localparam logic [7:0]  OFS_TSS_DATA    = 8'h14;

   // Field positions
   localparam int unsigned CTRL_PE_BIT     = 0;
   localparam int unsigned CTRL_IO_PRIVILEGE_LEVEL_LSB   = 4;
   localparam int unsigned CTRL_CPL_LSB    = 8;
   localparam int unsigned STAT_VM_BIT     = 12;
   localparam int unsigned STAT_FAULT_BIT  = 13;
   localparam int unsigned STAT_VEC_LSB    = 16;

   // Reset values
   localparam logic [15:0] RST_IOMAP_BASE  = 16'h0000;
   localparam logic [15:0] RST_TSS_LIMIT   = 16'h0000;

   // ==========================================================
   // Architectural figures
   localparam logic [7:0]  VEC_GP          = 8'h0d;
   localparam logic [7:0]  VEC_UD          = 8'h06;
   localparam logic [1:0]  PL_USER         = 2'h3;
   localparam logic [1:0]  PL_KERNEL       = 2'h0;
   localparam int unsigned SEG_SHIFT       = 4;
   localparam logic [20:0] LEGACY_ADDR_MAX = 21'h0fffff;
   localparam int unsigned PORT_BYTE_SHIFT = 3;
   localparam logic [7:0]  BYTE_ONES       = 8'hff;
   localparam logic [3:0]  MASK_BYTE       = 4'h1;
   localparam logic [3:0]  MASK_WORD       = 4'h3;
   localparam logic [3:0]  MASK_DWORD      = 4'hf;
   localparam int unsigned LANES           = 4;

   typedef enum logic [1:0] {IO_BYTE, IO_WORD, IO_DWORD} io_width_e;

   typedef enum logic [3:0] {
      OP_PLAIN, OP_PRIV, OP_PROT_ONLY, OP_IO_PRIVILEGE_LEVEL_SENS, OP_FLAGS_SENS, OP_UNCHECKED,
      OP_PORT_IO, OP_INTERRUPT, OP_INTERRUPT_RETURN_INSTR, OP_TASK_SWITCH, OP_PUSH_FLAGS,
      OP_POP_FLAGS, OP_MEM_REF
   } instr_class_e;

   typedef struct packed {
      instr_class_e op;
      logic         op32;
      logic [15:0]  io_port;
      io_width_e    io_width;
      logic [15:0]  selector;
      logic         gate_conforming;
      logic [1:0]   gate_dpl;
      logic         image_vm;
      logic         tss32;
      logic [15:0]  offset;
   } chk_req_s;

   typedef struct packed {
      logic         fault;
      logic [7:0]   vector;
      logic [15:0]  err_code;
      logic         image_vm;
      logic         seg_legacy;
      logic [20:0]  lin_addr;
   } chk_rsp_s;

endpackage
